// [pmrc_core.sv]
// Power-mode, power-up delay and stop recovery control with APB registers.
//
// What this block does
// R01 - Power-up delay is a one-shot started by supply good, recovery, watchdog.
// R02 - Delay timer counts on the internal RC tick or the crystal tick.
// R03 - Core is held off until the minimum power-up delay has elapsed.
// R04 - Delay-enable bit decides if recovery from stop runs the delay.
// R05 - Clock-gated sleep stops core clock; oscillator, timers, interrupts run.
// R06 - Interrupt leaves clock-gated sleep and resumes after the sleep opcode.
// R07 - Reset or watchdog ending clock-gated sleep restarts at 000CH.
// R08 - Oscillator-off sleep stops core clock and the crystal oscillator.
// R09 - Oscillator-off sleep ends only by watchdog, reset or recovery, at 000CH.
// R10 - Software issues a no-operation right before either sleep opcode.
// R11 - Recovery register bits are write-only except top bit, read-only.
// R12 - Top bit set by hardware on stop recovery, cleared by power-on.
// R13 - Bit six selects low or high active recovery source level.
// R14 - Bits two to four select the stop recovery source.
// R15 - Software writes zero to low two bits of second register.
// R16 - Bit zero adds divide-by-16; timer clock runs in clock-gated sleep.
// R17 - Divide-by-16 bit cleared after recovery, watchdog or power-up.
// R18 - Bit one clear halves the clocks; set passes external clock.
// R19 - Source code to wake input mapping is a parameter.
`timescale 1ns/1ps
`default_nettype none

module pmrc_core #(
  parameter int POR_CYCLES = pmrc_pkg::PMRC_POR_CYCLES,
  parameter logic [23:0] SRC_MAP = 24'hfac688
) (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire pmrc_pkg::pmrc_apb_req_type apb_req,
  output var  pmrc_pkg::pmrc_apb_rsp_type apb_rsp,
  input  wire logic                       supply_good,
  input  wire logic                       watchdog_timeout,
  input  wire logic                       rc_tick,
  input  wire logic                       xtal_tick,
  input  wire logic                       use_rc_clock,
  input  wire logic [7:0]                 wake_inputs,
  input  wire logic                       irq_pending,
  input  wire logic                       opcode_valid,
  input  wire logic [7:0]                 opcode,
  output logic                            core_run,
  output logic                            core_restart,
  output logic [15:0]                     restart_vector,
  output logic                            osc_enable,
  output logic                            counter_clock_en,
  output logic                            system_clock_en,
  output logic                            pipeline_fault,
  output logic                            irq
);
  import pmrc_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    pmrc_mode_type            mode;
    logic [7:0]               src_ctl;
    logic [1:0]               src_two;
    logic                     flag;
    logic [31:0]              dly_cnt;
    logic                     supply_prev;
    logic                     last_nop;
    logic [3:0]               div_cnt;
    logic                     half;
    logic [PMRC_EV_N-1:0]     status;
    logic [PMRC_EV_N-1:0]     enable;
    logic                     restart;
    logic                     fault;
    logic [31:0]              rdata;
  } pmrc_state_type;

  pmrc_state_type s_q;
  pmrc_state_type s_d;

  logic       access;
  logic       wr;
  logic       rd;
  logic       tick;
  logic       level;
  logic [2:0] src_sel;
  logic [2:0] map_idx;
  logic       recover;
  logic       supply_up;
  logic       divtick;
  logic [PMRC_EV_N-1:0] ev;

  always_comb begin
    access    = apb_req.psel & apb_req.penable;
    wr        = access & apb_req.pwrite;
    // Read data is latched in the setup cycle so it stands in the access cycle.
    rd        = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    tick      = use_rc_clock ? rc_tick : xtal_tick; // see R02
    src_sel   = s_q.src_ctl[PMRC_SRC_LO +: 3]; // see R14
    map_idx   = SRC_MAP[src_sel*3 +: 3]; // see R19
    level     = wake_inputs[map_idx] ^ ~s_q.src_ctl[PMRC_BIT_POL]; // see R13
    recover   = (s_q.mode == PMRC_STOP) && (src_sel != 3'h0) && level;
    supply_up = supply_good & ~s_q.supply_prev;
    divtick   = ~s_q.src_ctl[PMRC_BIT_DIV16] || (s_q.div_cnt == PMRC_DIV16_LAST);
    ev        = '0;
    ev[PMRC_EV_POR]  = supply_up;
    ev[PMRC_EV_WDT]  = watchdog_timeout;
    ev[PMRC_EV_SMR]  = recover;
    ev[PMRC_EV_WAKE] = (s_q.mode == PMRC_HALT) && irq_pending;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d             = s_q;
    s_d.supply_prev = supply_good;
    s_d.restart     = 1'b0;
    s_d.half        = s_q.src_ctl[PMRC_BIT_DIV1] ? 1'b1 : ~s_q.half; // see R18
    s_d.div_cnt     = s_q.div_cnt + ((s_q.src_ctl[PMRC_BIT_DIV1] | s_q.half) ? 4'h1 : 4'h0);
    if (opcode_valid && (s_q.mode == PMRC_RUN)) begin
      s_d.last_nop = (opcode == PMRC_OP_NOP);
      if (((opcode == PMRC_OP_STOP) || (opcode == PMRC_OP_HALT)) && !s_q.last_nop) begin
        s_d.fault = 1'b1; // see R10
      end
      if (opcode == PMRC_OP_STOP) begin
        s_d.mode = PMRC_STOP; // see R08
      end else if (opcode == PMRC_OP_HALT) begin
        s_d.mode = PMRC_HALT; // see R05
      end
    end
    if (s_q.mode == PMRC_HALT && irq_pending) begin
      s_d.mode = PMRC_RUN; // see R06
    end
    if (s_q.mode == PMRC_DELAY) begin
      if (tick) begin
        s_d.dly_cnt = s_q.dly_cnt - 32'h1;
      end
      if (s_q.dly_cnt == 32'h0) begin
        s_d.mode    = PMRC_RUN; // see R03
        s_d.restart = 1'b1; // see R07
      end
    end
    if (recover) begin
      s_d.flag = 1'b1; // see R12
      s_d.src_ctl[PMRC_BIT_DIV16] = 1'b0; // see R17
      if (s_q.src_ctl[PMRC_BIT_DLY]) begin
        s_d.mode    = PMRC_DELAY; // see R04
        s_d.dly_cnt = 32'(POR_CYCLES);
      end else begin
        s_d.mode    = PMRC_RUN;
        s_d.restart = 1'b1; // see R09
      end
    end
    if (supply_up || watchdog_timeout) begin
      s_d.mode    = PMRC_DELAY; // see R01
      s_d.dly_cnt = 32'(POR_CYCLES);
      s_d.src_ctl[PMRC_BIT_DIV16] = 1'b0; // see R17
      s_d.last_nop = 1'b0;
    end
    if (supply_up) begin
      s_d.flag = 1'b0; // see R12
    end
    s_d.rdata = 32'h0;
    if (wr) begin
      case (apb_req.paddr)
        PMRC_ADDR_SRC: begin
          s_d.src_ctl = apb_req.pwdata[7:0]; // see R11
        end
        PMRC_ADDR_SRC_TWO: begin
          s_d.src_two = apb_req.pwdata[1:0] & PMRC_TWO_MASK; // see R15
        end
        PMRC_ADDR_CLEAR: begin
          s_d.status = s_q.status & ~apb_req.pwdata[PMRC_EV_N-1:0];
        end
        PMRC_ADDR_ENABLE: begin
          s_d.enable = apb_req.pwdata[PMRC_EV_N-1:0];
        end
        PMRC_ADDR_CMD: begin
          s_d.fault = 1'b0;
        end
        default: begin
          s_d.status = s_q.status;
        end
      endcase
    end
    if (rd) begin
      case (apb_req.paddr)
        PMRC_ADDR_SRC: begin
          s_d.rdata[PMRC_BIT_FLAG] = s_q.flag; // see R11
        end
        PMRC_ADDR_STATUS: begin
          s_d.rdata[PMRC_EV_N-1:0] = s_q.status;
        end
        PMRC_ADDR_ENABLE: begin
          s_d.rdata[PMRC_EV_N-1:0] = s_q.enable;
        end
        PMRC_ADDR_STATE: begin
          s_d.rdata[2:0] = {s_q.fault, s_q.mode == PMRC_STOP,
                            s_q.mode == PMRC_HALT};
        end
        default: begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
    s_d.status = s_d.status | ev;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.mode    <= PMRC_DELAY;
      s_q.dly_cnt <= 32'(POR_CYCLES);
      s_q.src_ctl <= PMRC_SRC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb begin
    apb_rsp.pready   = 1'b1;
    apb_rsp.pslverr  = 1'b0;
    apb_rsp.prdata   = s_q.rdata;
    core_run         = (s_q.mode == PMRC_RUN); // see R03
    core_restart     = s_q.restart;
    restart_vector   = PMRC_RESTART_VEC;
    osc_enable       = (s_q.mode != PMRC_STOP); // see R08
    counter_clock_en = osc_enable & divtick & (s_q.half | s_q.src_ctl[PMRC_BIT_DIV1]); // see R16
    system_clock_en  = counter_clock_en & core_run; // see R05
    pipeline_fault   = s_q.fault;
    irq              = |(s_q.status & s_q.enable);
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_stop_osc_off: assert property (@(posedge clock) disable iff (sys_rst) // see R08
    s_q.mode == PMRC_STOP |-> !osc_enable)
    else $error("Oscillator runs in stop.");
  a_halt_no_core: assert property (@(posedge clock) disable iff (sys_rst) // see R05
    s_q.mode == PMRC_HALT |-> !system_clock_en && osc_enable)
    else $error("Core clock runs in halt.");
  a_recov_flag: assert property (@(posedge clock) disable iff (sys_rst) // see R12
    recover && !supply_up |=> s_q.flag)
    else $error("Recovery flag not set.");
  a_div16_clear: assert property (@(posedge clock) disable iff (sys_rst) // see R17
    watchdog_timeout |=> !s_q.src_ctl[PMRC_BIT_DIV16])
    else $error("Divide select not cleared.");
  a_delay_start: assert property (@(posedge clock) disable iff (sys_rst) // see R01
    supply_up |=> s_q.mode == PMRC_DELAY && s_q.dly_cnt == 32'(POR_CYCLES))
    else $error("Delay not started.");
  a_delay_hold: assert property (@(posedge clock) disable iff (sys_rst) // see R03
    s_q.mode == PMRC_DELAY && s_q.dly_cnt != 32'h0 |-> !core_run)
    else $error("Core runs during delay.");
  a_bypass_dly: assert property (@(posedge clock) disable iff (sys_rst) // see R04
    recover && !s_q.src_ctl[PMRC_BIT_DLY] && !supply_up && !watchdog_timeout
    |=> core_run && core_restart)
    else $error("Delay bypass failed.");
  a_halt_wake: assert property (@(posedge clock) disable iff (sys_rst) // see R06
    s_q.mode == PMRC_HALT && irq_pending && !supply_up && !watchdog_timeout
    |=> core_run && !core_restart)
    else $error("Halt wake wrong.");
  a_full_clock: assert property (@(posedge clock) disable iff (sys_rst) // see R18
    s_q.src_ctl[PMRC_BIT_DIV1] && !s_q.src_ctl[PMRC_BIT_DIV16] && osc_enable
    |-> counter_clock_en)
    else $error("Full rate clock missing.");

  // ------------------------------------------------------------------
  // Checks on mode changes, delay count, fault, flags and events
  // ------------------------------------------------------------------
  a_restart_vec: assert property (@(posedge clock) disable iff (sys_rst) // see R07
    core_restart |-> restart_vector == PMRC_RESTART_VEC)
    else $error("Restart vector wrong.");
  a_delay_end: assert property (@(posedge clock) disable iff (sys_rst) // see R03
    s_q.mode == PMRC_DELAY && s_q.dly_cnt == 32'h0 && !supply_up
    && !watchdog_timeout |=> core_run && core_restart)
    else $error("Delay end missed.");
  a_wdt_delay: assert property (@(posedge clock) disable iff (sys_rst) // see R01
    watchdog_timeout |=> s_q.mode == PMRC_DELAY
    && s_q.dly_cnt == 32'(POR_CYCLES))
    else $error("Watchdog delay not started.");
  a_delay_count: assert property (@(posedge clock) disable iff (sys_rst) // see R02
    s_q.mode == PMRC_DELAY && tick && s_q.dly_cnt != 32'h0 && !supply_up
    && !watchdog_timeout |=> s_q.dly_cnt == $past(s_q.dly_cnt) - 32'h1)
    else $error("Delay tick not counted.");
  a_recov_delay: assert property (@(posedge clock) disable iff (sys_rst) // see R04
    recover && s_q.src_ctl[PMRC_BIT_DLY] && !supply_up && !watchdog_timeout
    |=> s_q.mode == PMRC_DELAY)
    else $error("Recovery delay skipped.");
  a_stop_hold: assert property (@(posedge clock) disable iff (sys_rst) // see R09
    s_q.mode == PMRC_STOP && !recover && !supply_up && !watchdog_timeout
    |=> s_q.mode == PMRC_STOP)
    else $error("Stop left without cause.");
  a_halt_hold: assert property (@(posedge clock) disable iff (sys_rst) // see R06
    s_q.mode == PMRC_HALT && !irq_pending && !supply_up && !watchdog_timeout
    |=> s_q.mode == PMRC_HALT)
    else $error("Halt left without cause.");
  a_stop_enter: assert property (@(posedge clock) disable iff (sys_rst) // see R08
    opcode_valid && s_q.mode == PMRC_RUN && opcode == PMRC_OP_STOP
    && !supply_up && !watchdog_timeout |=> s_q.mode == PMRC_STOP)
    else $error("Stop not entered.");
  a_halt_enter: assert property (@(posedge clock) disable iff (sys_rst) // see R05
    opcode_valid && s_q.mode == PMRC_RUN && opcode == PMRC_OP_HALT
    && !supply_up && !watchdog_timeout |=> s_q.mode == PMRC_HALT)
    else $error("Halt not entered.");
  a_fault_set: assert property (@(posedge clock) disable iff (sys_rst) // see R10
    opcode_valid && s_q.mode == PMRC_RUN && opcode == PMRC_OP_STOP
    && !s_q.last_nop && !(wr && apb_req.paddr == PMRC_ADDR_CMD)
    |=> s_q.fault)
    else $error("Missing no-operation not flagged.");
  a_flag_por: assert property (@(posedge clock) disable iff (sys_rst) // see R12
    supply_up |=> !s_q.flag)
    else $error("Recovery flag not cleared.");
  a_flag_keep: assert property (@(posedge clock) disable iff (sys_rst) // see R12
    s_q.flag && !supply_up |=> s_q.flag)
    else $error("Recovery flag lost.");
  a_recov_div16: assert property (@(posedge clock) disable iff (sys_rst) // see R17
    recover && !(wr && apb_req.paddr == PMRC_ADDR_SRC)
    |=> !s_q.src_ctl[PMRC_BIT_DIV16])
    else $error("Divide select kept after recovery.");
  a_recov_event: assert property (@(posedge clock) disable iff (sys_rst) // see R12
    recover |=> s_q.status[PMRC_EV_SMR])
    else $error("Recovery event not recorded.");
  a_event_sticky: assert property (@(posedge clock) disable iff (sys_rst) // see R12
    s_q.status[PMRC_EV_SMR] && !(wr && apb_req.paddr == PMRC_ADDR_CLEAR)
    |=> s_q.status[PMRC_EV_SMR])
    else $error("Event bit lost.");

  // ------------------------------------------------------------------
  // Checks on clocks
  // ------------------------------------------------------------------
  a_halt_osc: assert property (@(posedge clock) disable iff (sys_rst) // see R05
    s_q.mode == PMRC_HALT |-> osc_enable)
    else $error("Oscillator stopped in halt.");
  a_stop_no_clk: assert property (@(posedge clock) disable iff (sys_rst) // see R08
    s_q.mode == PMRC_STOP |-> !counter_clock_en)
    else $error("Timer clock runs in stop.");
  a_halt_timer: assert property (@(posedge clock) disable iff (sys_rst) // see R16
    s_q.mode == PMRC_HALT && s_q.src_ctl[PMRC_BIT_DIV1]
    && !s_q.src_ctl[PMRC_BIT_DIV16] |-> counter_clock_en)
    else $error("Timer clock stopped in halt.");
  a_div16_rate: assert property (@(posedge clock) disable iff (sys_rst) // see R16
    counter_clock_en && s_q.src_ctl[PMRC_BIT_DIV16]
    |-> s_q.div_cnt == PMRC_DIV16_LAST)
    else $error("Divide by sixteen rate wrong.");
  a_half_toggle: assert property (@(posedge clock) disable iff (sys_rst) // see R18
    !s_q.src_ctl[PMRC_BIT_DIV1] |=> s_q.half != $past(s_q.half))
    else $error("Half rate phase stuck.");
  a_half_rate: assert property (@(posedge clock) disable iff (sys_rst) // see R18
    counter_clock_en && !s_q.src_ctl[PMRC_BIT_DIV1] |-> s_q.half)
    else $error("Half rate clock too fast.");

endmodule : pmrc_core
`default_nettype wire

// [pmrc_pkg.sv]
// Package with constants and types of the power-mode recovery control block.
package pmrc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] PMRC_IDX_SRC      = 8'h0b;
  localparam logic [7:0] PMRC_IDX_SRC_TWO  = 8'h0d;
  localparam logic [11:0] PMRC_ADDR_SRC     = {2'h0, PMRC_IDX_SRC, 2'h0};
  localparam logic [11:0] PMRC_ADDR_SRC_TWO = {2'h0, PMRC_IDX_SRC_TWO, 2'h0};
  localparam logic [11:0] PMRC_ADDR_STATUS  = 12'h040;
  localparam logic [11:0] PMRC_ADDR_CLEAR   = 12'h044;
  localparam logic [11:0] PMRC_ADDR_ENABLE  = 12'h048;
  localparam logic [11:0] PMRC_ADDR_CMD     = 12'h04c;
  localparam logic [11:0] PMRC_ADDR_STATE   = 12'h050;

  // ------------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------------
  localparam int PMRC_BIT_DIV16 = 0;
  localparam int PMRC_BIT_DIV1  = 1;
  localparam int PMRC_SRC_LO    = 2;
  localparam int PMRC_BIT_POL   = 6;
  localparam int PMRC_BIT_DLY   = 5;
  localparam int PMRC_BIT_FLAG  = 7;
  localparam logic [7:0] PMRC_SRC_RESET = 8'h00;
  localparam logic [1:0] PMRC_TWO_MASK  = 2'h3;

  localparam logic [7:0] PMRC_OP_NOP  = 8'hff;
  localparam logic [7:0] PMRC_OP_STOP = 8'h6f;
  localparam logic [7:0] PMRC_OP_HALT = 8'h7f;
  localparam logic [15:0] PMRC_RESTART_VEC = 16'h000c;

  localparam int PMRC_EV_N    = 4;
  localparam int PMRC_EV_POR  = 0;
  localparam int PMRC_EV_WDT  = 1;
  localparam int PMRC_EV_SMR  = 2;
  localparam int PMRC_EV_WAKE = 3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int PMRC_CLK_MHZ    = 50;
  localparam int PMRC_TPOR_US    = 5;
  localparam int PMRC_POR_CYCLES = PMRC_TPOR_US * PMRC_CLK_MHZ;
  localparam logic [3:0] PMRC_DIV16_LAST = 4'hf;

  typedef enum {PMRC_RUN, PMRC_HALT, PMRC_STOP, PMRC_DELAY} pmrc_mode_type;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmrc_apb_req_type;

  typedef struct packed {
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
  } pmrc_apb_rsp_type;

endpackage : pmrc_pkg

// [pmrc_osc_model.sv]
// Oscillator and delay tick model on the far side of the block.
`timescale 1ns/1ps
`default_nettype none

module pmrc_osc_model (
  input  wire logic osc_enable,
  output logic      rc_tick,
  output logic      xtal_tick
);
  // ----------------------------------------------------------------
  // Tick sources
  // ----------------------------------------------------------------
  // The RC source runs always; the crystal stops while disabled.
  assign rc_tick   = 1'b1;
  assign xtal_tick = osc_enable;
endmodule : pmrc_osc_model

`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the power-mode recovery control block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pmrc_pkg::*;
  localparam int POR = 8;
  logic             clock;
  logic             sys_rst;
  pmrc_apb_req_type req;
  pmrc_apb_rsp_type rsp;
  logic             supply_good, wdt, use_rc, irqp, opv, osc_en, rc_t, xt_t;
  logic             core_run, core_restart, cnt_en, irq;
  logic [7:0]       wake, op;
  logic [15:0]      vec;
  logic [31:0]      rdata;
  int               err_total, checks, cyc, rs_cnt, r0, n;

  pmrc_core #(.POR_CYCLES(POR)) dut_u (.clock(clock), .sys_rst(sys_rst),
    .apb_req(req), .apb_rsp(rsp), .supply_good(supply_good),
    .watchdog_timeout(wdt), .rc_tick(rc_t), .xtal_tick(xt_t),
    .use_rc_clock(use_rc), .wake_inputs(wake), .irq_pending(irqp),
    .opcode_valid(opv), .opcode(op), .core_run(core_run),
    .core_restart(core_restart), .restart_vector(vec),
    .osc_enable(osc_en), .counter_clock_en(cnt_en),
    .system_clock_en(), .pipeline_fault(), .irq(irq));
  pmrc_osc_model osc_u (.osc_enable(osc_en), .rc_tick(rc_t),
    .xtal_tick(xt_t));

  // ----------------------------------------------------------------
  // Clock, monitors and tasks
  // ----------------------------------------------------------------
  always #10 clock = ~clock;
  always @(posedge core_restart) if (core_restart === 1'b1) rs_cnt++;

  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rdata = rsp.prdata;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    if (k == 20) begin err_total++; finish_test(); end
    #1;
  endtask : acc

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    acc(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rd

  task automatic wait_run();
    cyc = 0;
    #1;
    while (core_run !== 1'b1 && cyc < 400) begin
      @(posedge clock);
      #1;
      cyc++;
    end
    if (core_run !== 1'b1) begin err_total++; finish_test(); end
  endtask : wait_run

  task automatic sleep(input logic [7:0] s);
    @(posedge clock);
    opv <= 1'b1;
    op  <= PMRC_OP_NOP;
    @(posedge clock);
    op  <= s;
    @(posedge clock);
    opv <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask : sleep

  task automatic count_clk(input int e);
    n = 0;
    repeat (64) begin
      @(posedge clock);
      #1;
      n += int'(cnt_en);
    end
    chk(n, e);
  endtask : count_clk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 0; sys_rst = 1; req = '0; supply_good = 1; wdt = 0; use_rc = 1;
    irqp = 0; opv = 0; op = 8'h00; wake = 8'h00;
    err_total = 0; checks = 0; rs_cnt = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    wait_run();
    chk(cyc >= POR, 1);
    chk({16'h0, vec}, 32'h000c);
    chk(rs_cnt, 1);
    @(posedge clock);
    supply_good <= 1'b0;
    @(posedge clock);
    supply_good <= 1'b1;
    @(posedge clock);
    wait_run();
    chk(rs_cnt, 2);
    rd(PMRC_ADDR_SRC, 32'h0);
    rd(12'h100, 32'h0);
    sleep(PMRC_OP_HALT);
    chk({core_run, osc_en}, 2'b01);
    rd(PMRC_ADDR_STATE, 32'h1);
    count_clk(32);
    @(posedge clock);
    irqp <= 1'b1;
    wait_run();
    chk(rs_cnt, 2);
    @(posedge clock);
    irqp <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      acc(1'b1, PMRC_ADDR_SRC, {25'h0, p[0], 6'h04});
      acc(1'b1, PMRC_ADDR_SRC_TWO, 32'h0);
      @(posedge clock);
      wake[1] <= ~p[0];
      sleep(PMRC_OP_STOP);
      chk({core_run, osc_en}, 2'b00);
      repeat (5) @(posedge clock);
      chk(core_run, 1'b0);
      r0 = rs_cnt;
      @(posedge clock);
      wake[1] <= p[0];
      wait_run();
      chk(cyc < POR, 1);
      chk(rs_cnt, r0 + 1);
      rd(PMRC_ADDR_SRC, 32'h80);
    end
    rd(PMRC_ADDR_STATUS, 32'h0d);
    acc(1'b1, PMRC_ADDR_ENABLE, 32'h4);
    chk(irq, 1'b1);
    acc(1'b1, PMRC_ADDR_ENABLE, 32'h0);
    chk(irq, 1'b0);
    acc(1'b1, PMRC_ADDR_ENABLE, 32'h4);
    acc(1'b1, PMRC_ADDR_CLEAR, 32'h4);
    chk(irq, 1'b0);
    rd(PMRC_ADDR_STATUS, 32'h09);
    @(posedge clock);
    wake[1] <= 1'b0;
    acc(1'b1, PMRC_ADDR_SRC, 32'h64);
    sleep(PMRC_OP_STOP);
    @(posedge clock);
    wake[1] <= 1'b1;
    wait_run();
    chk(cyc >= POR, 1);
    acc(1'b1, PMRC_ADDR_SRC, 32'h01);
    count_clk(2);
    sleep(PMRC_OP_STOP);
    r0 = rs_cnt;
    @(posedge clock);
    wdt <= 1'b1;
    @(posedge clock);
    wdt <= 1'b0;
    wait_run();
    chk(rs_cnt, r0 + 1);
    count_clk(32);
    acc(1'b1, PMRC_ADDR_SRC, 32'h02);
    count_clk(64);
    finish_test();
  end
endmodule : testbench

`default_nettype wire
